// [dv/sbo_bmc_model.sv]
// Behavioural board controller driving the shared enable and side-band pins.
`timescale 1ns/1ps
`default_nettype none
module sbo_bmc_model (
  // Shared pins toward the device.
  output logic      sclk_o,
  output logic      ld_n_o,
  output logic      din_o,
  output logic      en2_o,
  // Serial data back from the device.
  input  wire logic so_i
);
  logic [7:0] rec = 8'h00;

  // Start with every enable pin released high.
  initial begin
    {ld_n_o, din_o, sclk_o, en2_o} = 4'hF;
  end

  // Plain pin levels, bit 3 for out13 down to bit 0 for out2; the 1 ns step keeps changes
  // clear of the device clock edge.
  task automatic pins(input logic [3:0] n);
    #1;
    {ld_n_o, din_o, sclk_o, en2_o} = n;
  endtask

  // One 30 ns serial clock; data-out is read at the falling edge, after the bit has moved.
  task automatic tick(input logic d);
    #1;
    din_o = d;
    #6;
    sclk_o = 1'b1;
    #15;
    sclk_o = 1'b0;
    rec = {rec[6:0], so_i};
    #8;
  endtask

  // Whole frame: shifting on, n bits first to last, data released to its pull-down, load off.
  task automatic frame(input logic [7:0] w, input int n);
    #1;
    ld_n_o = 1'b1;
    for (int i = n - 1; i >= 0; i--) tick(w[i]);
    #15;
    din_o = 1'b0;
    #15;
    ld_n_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/sbo_tb_top.sv]
// Self-checking bench for the side-band output enable top.
`timescale 1ns/1ps
`default_nettype none
module sbo_tb_top;
  import sbo_pkg::*;
  localparam logic [6:0] BASE = 7'h10;
  logic         clk = 0, rst_n = 0, strap = 0, pg = 0;
  logic         m2, sclk, ld_n, din, so, oe, pull, pd;
  logic [1:0]   a_hi = TRI_HIGH, a_lo = TRI_MID, rresp;
  logic [3:0]   ded_n = 4'hF, den, dded;
  logic [6:0]   badr;
  logic [31:0]  rdat;
  sbo_axi_req_s rq = '0;
  sbo_axi_rsp_s rs;
  int           err_total = 0, cmp_count = 0;

  // Reference clock, 5 ns period.
  always #2.5 clk = ~clk;

  // Device; out2 pin level is the device while it drives, else the controller.
  sbo_top #(.ADDR_BASE(BASE)) dut_u (
    .REF_CLK_I(clk), .RSTN_I(rst_n), .AXI_REQ_I(rq), .AXI_RSP_O(rs),
    .SIDEBAND_SELECT_STRAP_I(strap), .POWER_GOOD_POWERDOWN_N_I(pg),
    .BUS_ADDRESS_STRAP_HI_I(a_hi), .BUS_ADDRESS_STRAP_LO_I(a_lo),
    .OUT13_ENABLE_OR_SHIFT_LOAD_N_I(ld_n), .OUT9_ENABLE_OR_SERIAL_IN_I(din),
    .OUT5_ENABLE_OR_SERIAL_CLOCK_I(sclk), .OUT2_ENABLE_OR_SERIAL_OUT_I(oe ? so : m2),
    .OUT2_ENABLE_OR_SERIAL_OUT_O(so), .OUT2_ENABLE_OR_SERIAL_OUT_OE_O(oe),
    .SHARED_PIN_PULL_UP_O(pull), .DED_ENABLE_N_I(ded_n), .DIFF_OUTPUT_EN_O(den),
    .DED_OUTPUT_EN_O(dded), .POWER_DOWN_O(pd), .BUS_ADDRESS_O(badr));
  sbo_bmc_model bmc_u (.sclk_o(sclk), .ld_n_o(ld_n), .din_o(din), .en2_o(m2), .so_i(so));

  // Counts one comparison and reports a mismatch.
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bus write; the leading edge keeps back-to-back calls from driving twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw = 1, w = 1;
    @(posedge clk);
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (rs.awready) aw = 0;
      if (rs.wready) w = 0;
      rq.awvalid <= aw;
      rq.wvalid <= w;
    end
    do @(posedge clk); while (!rs.bvalid);
    rresp = rs.bresp;
    rq.bready <= 1'b0;
  endtask

  // Bus read, then comparison of data and response.
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do @(posedge clk); while (!rs.arready);
    rq.arvalid <= 1'b0;
    do @(posedge clk); while (!rs.rvalid);
    rq.rready <= 1'b0;
    cmp("rdata", e, rs.rdata);
    cmp("rresp", r, rs.rresp);
  endtask

  // Reset with three link clocks inside it, so the link side clears too.
  task automatic reset_to(input logic sb);
    rst_n <= 1'b0;
    strap <= sb;
    pg <= 1'b0;
    repeat (3) bmc_u.tick(1'b0);
    bmc_u.pins({4{!sb}});
    @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // Reset values, read-only and unmapped words; outputs stay off before power good.
  task automatic t_regs();
    ded_n <= 4'h0;
    bmc_u.pins(4'h0);
    rchk(OFS_OE_CTRL, {24'h0, OE_CTRL_RST}, RESP_OKAY);
    rchk(OFS_SB_CTL, {28'h0, SB_CTL_RST}, RESP_OKAY);
    rchk(OFS_BUS_ADDR, 32'h0, RESP_OKAY);
    wr(OFS_STATUS, 32'hFFFFFFFF);
    cmp("wresp", RESP_OKAY, rresp);
    rchk(OFS_STATUS, 32'h0, RESP_OKAY);
    rchk(8'h10, 32'h0, RESP_SLVERR);
    cmp("out_en", 8'h00, {den, dded});
    $display("test regs done");
  endtask

  // Enable mode: start-up, address decode, one pin at a time, register gating.
  task automatic t_enable();
    pg <= 1'b1;
    cyc(10);
    cmp("badr", 7'(BASE + 3 * TRI_HIGH + TRI_MID), badr);
    rchk(OFS_STATUS, 32'h2, RESP_OKAY);
    cmp("pull", 1'b1, pull);
    cmp("serial_oe", 1'b0, oe);
    for (int i = 0; i < 4; i++) begin
      ded_n <= ~(4'h1 << i);
      bmc_u.pins(~(4'h1 << i));
      cyc(8);
      cmp("diff_en", 4'h1 << i, den);
      cmp("ded_en", 4'h1 << i, dded);
    end
    ded_n <= 4'hF;
    cyc(10);
    cmp("ded_en", 4'h0, dded);
    ded_n <= 4'h0;
    bmc_u.pins(4'h0);
    wr(OFS_OE_CTRL, 32'h5A);
    cyc(6);
    cmp("out_en", 8'hA5, {den, dded});
    $display("test enable done");
  endtask

  // Power down and back, with the address straps moved while down.
  task automatic t_pd();
    pg <= 1'b0;
    a_hi <= TRI_LOW;
    a_lo <= TRI_LOW;
    cyc(10);
    cmp("pd", 1'b1, pd);
    cmp("out_en", 8'h00, {den, dded});
    pg <= 1'b1;
    cyc(10);
    cmp("pd", 1'b0, pd);
    cmp("badr", 7'(BASE + 3 * TRI_HIGH + TRI_MID), badr);
    cmp("out_en", 8'hA5, {den, dded});
    $display("test power down done");
  endtask

  // Side-band mode: eight-bit frame for daisy chain, gating, and shifting held off.
  task automatic t_side();
    pg <= 1'b1;
    cyc(10);
    rchk(OFS_STATUS, 32'h3, RESP_OKAY);
    cmp("pull", 1'b0, pull);
    cmp("serial_oe", 1'b1, oe);
    // The link needs two serial clocks, load held low, to see the released reset and the mode.
    repeat (2) bmc_u.tick(1'b0);
    bmc_u.frame(8'hA3, 8);
    cyc(12);
    rchk(OFS_SB_CTL, 32'h3, RESP_OKAY);
    cmp("diff_en", 4'hC, den);
    cmp("chain_out", 5'b10100, bmc_u.rec[4:0]);
    ded_n <= 4'h0;
    wr(OFS_OE_CTRL, 32'h74);
    cyc(6);
    cmp("out_en", 8'h47, {den, dded});
    repeat (4) bmc_u.tick(1'b0);
    bmc_u.frame(8'h00, 0);
    cyc(12);
    rchk(OFS_SB_CTL, 32'h3, RESP_OKAY);
    $display("test side-band done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence; the second reset switches the strap and restores the register reset values between runs.
  initial begin
    reset_to(1'b0);
    t_regs();
    t_enable();
    t_pd();
    reset_to(1'b1);
    t_side();
    complete_run();
  end

  // The tests need under 2 us; a hang is cut off well past that.
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire

// [dv/sbo_top_assertions.sv]
// Port-level checks for the side-band output enable top.
`timescale 1ns/1ps
`default_nettype none
module sbo_top_assertions
  import sbo_pkg::*;
(
  // Clock and reset.
  input wire logic                  REF_CLK_I,
  input wire logic                  RSTN_I,
  // Inputs watched.
  input wire sbo_pkg::sbo_axi_req_s AXI_REQ_I,
  input wire logic                  POWER_GOOD_POWERDOWN_N_I,
  input wire logic                  OUT13_ENABLE_OR_SHIFT_LOAD_N_I,
  input wire logic [N_DED-1:0]      DED_ENABLE_N_I,
  // Outputs watched.
  input wire sbo_pkg::sbo_axi_rsp_s AXI_RSP_O,
  input wire logic                  OUT2_ENABLE_OR_SERIAL_OUT_OE_O,
  input wire logic                  SHARED_PIN_PULL_UP_O,
  input wire logic [N_SHARED-1:0]   DIFF_OUTPUT_EN_O,
  input wire logic [N_DED-1:0]      DED_OUTPUT_EN_O,
  input wire logic                  POWER_DOWN_O
);
  // All checks share the reference clock and sleep in reset.
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // Repeats give the registered output stages time to settle after a pin change.
  pd_silence_a: assert property (POWER_DOWN_O [*2] |-> {DIFF_OUTPUT_EN_O, DED_OUTPUT_EN_O} == 8'h00)
    else $error("output driven in power down");
  pd_exit_a: assert property (POWER_GOOD_POWERDOWN_N_I [*8] |-> !POWER_DOWN_O)
    else $error("power down while power good high");
  ded_off_a: assert property ((DED_ENABLE_N_I == 4'hF) [*8] |-> DED_OUTPUT_EN_O == 4'h0)
    else $error("dedicated output on with pin high");
  shared_off_a: assert property (
    (!OUT2_ENABLE_OR_SERIAL_OUT_OE_O && OUT13_ENABLE_OR_SHIFT_LOAD_N_I) [*8]
    |-> !DIFF_OUTPUT_EN_O[SH_OUT13]) else $error("shared output on with pin high");
  pull_mode_a: assert property (OUT2_ENABLE_OR_SERIAL_OUT_OE_O [*3] |-> !SHARED_PIN_PULL_UP_O)
    else $error("pull-up kept in side-band mode");
  wr_answer_a: assert property (AXI_REQ_I.awvalid && AXI_RSP_O.awready && AXI_REQ_I.wvalid
    && AXI_RSP_O.wready |-> ##2 AXI_RSP_O.bvalid) else $error("write answer late");
  b_done_a: assert property (AXI_RSP_O.bvalid && AXI_REQ_I.bready
    |=> !AXI_RSP_O.bvalid && AXI_RSP_O.awready) else $error("write response stuck");
  rd_answer_a: assert property (AXI_REQ_I.arvalid && AXI_RSP_O.arready
    |=> AXI_RSP_O.rvalid && !AXI_RSP_O.arready) else $error("read answer late");

  // Main scenarios reached.
  cover property ($rose(POWER_DOWN_O));
  cover property (OUT2_ENABLE_OR_SERIAL_OUT_OE_O && DIFF_OUTPUT_EN_O != 4'h0);
  cover property (AXI_RSP_O.rvalid && AXI_RSP_O.rresp == RESP_SLVERR);
endmodule
// Every instance of the top carries the checks.
bind sbo_top sbo_top_assertions chk_u (.*);
`default_nettype wire

// [logic/sbo_link_shift.sv]
// Side-band shift register that runs on the serial clock pin.
`timescale 1ns/1ps
`default_nettype none
module sbo_link_shift
  import sbo_pkg::*;
(
  // Link clock and raw reset.
  input  wire logic                link_clk_i,
  input  wire logic                rst_n_i,
  // Side-band pins and mode.
  input  wire logic                sb_mode_i,
  input  wire logic                shift_load_n_i,
  input  wire logic                serial_in_i,
  // Results.
  output logic [N_SHARED-1:0]      shreg_o,
  output logic                     serial_out_o
);

  // State of the link domain.
  typedef struct packed {
    logic [1:0]          rst_sync;
    logic [1:0]          mode_sync;
    logic [N_SHARED-1:0] shreg;
    logic                ser_out;
  } sbo_link_s;

  sbo_link_s st_r;
  sbo_link_s st_nxt;

  // The reset and the mode come from the reference domain, so both pass two flops here.
  // Load and data are launched by the partner on this clock and are sampled directly.
  always_comb begin
    st_nxt           = st_r;
    st_nxt.rst_sync  = {st_r.rst_sync[0], rst_n_i};
    st_nxt.mode_sync = {st_r.mode_sync[0], sb_mode_i};
    if (!st_r.rst_sync[1]) begin
      st_nxt.shreg   = SB_CTL_RST;
      st_nxt.ser_out = SB_CTL_RST[N_SHARED-1];
    end else if (st_r.mode_sync[1] && shift_load_n_i) begin
      st_nxt.shreg   = {st_r.shreg[N_SHARED-2:0], serial_in_i};
      st_nxt.ser_out = st_nxt.shreg[N_SHARED-1];
    end
  end

  // The clock may stop between frames; the register simply holds then.
  always_ff @(posedge link_clk_i) begin
    st_r <= st_nxt;
  end

  assign shreg_o      = st_r.shreg;
  assign serial_out_o = st_r.ser_out;

endmodule
`default_nettype wire

// [logic/sbo_pkg.sv]
// Package with constants, carrier types and register map of the side-band output enable control.
// How it works
// - Strap low gives enables, high gives side-band.
// - Register bits and dedicated pins still gate outputs.
// - First power-good rise latches straps, starts up.
// - Power-good low powers down; high resumes, no resample.
// - Shift-load low stops shifting, high allows it.
// - Each serial clock rise shifts one bit.
// - Serial data-in pin feeds the shift register.
// - Data-out pin drives serial out in side-band mode.
// - Enables are active low: low drives output.
// - Undriven shared pin pulls high, side-band pulls low.
// - Outputs 13, 9, 5, 2 have separate enables.
// - Two three-level straps decode the bus address.
// - Shift-load fall copies shift register to control.
`default_nettype none
package sbo_pkg;

  // Widths of the enable groups and of the register bus.
  localparam int N_SHARED = 4;
  localparam int N_DED    = 4;
  localparam int CTRL_W   = N_SHARED + N_DED;
  localparam int AXI_AW   = 8;
  localparam int BADDR_W  = 7;

  // Register byte offsets.
  localparam logic [AXI_AW-1:0] OFS_OE_CTRL  = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_STATUS   = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_SB_CTL   = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_BUS_ADDR = 8'h0C;

  // Reset values: every register enable set, every side-band enable off (active low).
  localparam logic [CTRL_W-1:0]   OE_CTRL_RST = 8'hFF;
  localparam logic [N_SHARED-1:0] SB_CTL_RST  = 4'hF;
  localparam logic [BADDR_W-1:0]  BADDR_RST   = 7'h00;

  // Field positions of the status register.
  localparam int STAT_SB_MODE = 0;
  localparam int STAT_RUN     = 1;
  localparam int STAT_PWRDN   = 2;

  // Field position of the dedicated enables inside the enable register.
  localparam int CTRL_DED_LSB = N_SHARED;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Three-level strap codes; the unused code reads as the middle level.
  localparam logic [1:0] TRI_LOW  = 2'h0;
  localparam logic [1:0] TRI_MID  = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;
  localparam logic [3:0] TRI_LEVELS = 4'h3;

  // Bit of each shared output inside the shift word and the enable vectors.
  localparam int SH_OUT2  = 0;
  localparam int SH_OUT5  = 1;
  localparam int SH_OUT9  = 2;
  localparam int SH_OUT13 = 3;

  // Start-up and power states.
  typedef enum logic [1:0] {
    ST_WAIT_PG,
    ST_RUN,
    ST_PWRDN
  } sbo_state_e;

  // AXI4-Lite request from the master.
  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [AXI_AW-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } sbo_axi_req_s;

  // AXI4-Lite response to the master.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } sbo_axi_rsp_s;

endpackage
`default_nettype wire

// [logic/sbo_top.sv]
// Top of the side-band output enable control with its AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
module sbo_top
  import sbo_pkg::*;
#(
  parameter logic [BADDR_W-1:0] ADDR_BASE = 7'h10
)(
  // Reference clock and reset.
  input  wire logic                    REF_CLK_I,
  input  wire logic                    RSTN_I,
  // Register bus.
  input  wire sbo_pkg::sbo_axi_req_s   AXI_REQ_I,
  output sbo_pkg::sbo_axi_rsp_s        AXI_RSP_O,
  // Straps and power control.
  input  wire logic                    SIDEBAND_SELECT_STRAP_I,
  input  wire logic                    POWER_GOOD_POWERDOWN_N_I,
  input  wire logic [1:0]              BUS_ADDRESS_STRAP_HI_I,
  input  wire logic [1:0]              BUS_ADDRESS_STRAP_LO_I,
  // Shared pins; the serial clock pin is also the link clock.
  input  wire logic                    OUT13_ENABLE_OR_SHIFT_LOAD_N_I,
  input  wire logic                    OUT9_ENABLE_OR_SERIAL_IN_I,
  input  wire logic                    OUT5_ENABLE_OR_SERIAL_CLOCK_I,
  input  wire logic                    OUT2_ENABLE_OR_SERIAL_OUT_I,
  output logic                         OUT2_ENABLE_OR_SERIAL_OUT_O,
  output logic                         OUT2_ENABLE_OR_SERIAL_OUT_OE_O,
  output logic                         SHARED_PIN_PULL_UP_O,
  // Dedicated enable pins, active low.
  input  wire logic [N_DED-1:0]        DED_ENABLE_N_I,
  // Results.
  output logic [N_SHARED-1:0]          DIFF_OUTPUT_EN_O,
  output logic [N_DED-1:0]             DED_OUTPUT_EN_O,
  output logic                         POWER_DOWN_O,
  output logic [BADDR_W-1:0]           BUS_ADDRESS_O
);

  // State of the reference domain.
  typedef struct packed {
    logic [1:0]             strap_sync;
    logic [2:0]             pg_sync;
    logic [2:0]             ld_sync;
    logic [1:0]             in9_sync;
    logic [1:0]             diff_output_5_sync;
    logic [1:0]             out2_sync;
    logic [1:0][N_DED-1:0]  ded_sync;
    logic [1:0][1:0]        adr_hi_sync;
    logic [1:0][1:0]        adr_lo_sync;
    sbo_state_e             state;
    logic                   sb_mode;
    logic [BADDR_W-1:0]     bus_addr;
    logic [CTRL_W-1:0]      ctrl;
    logic [N_SHARED-1:0]    sb_ctl;
    logic [N_SHARED-1:0]    out_en;
    logic [N_DED-1:0]       ded_en;
    logic                   pwrdn;
    logic                   pull_up;
    logic                   out2_oe;
    logic                   aw_got;
    logic [AXI_AW-1:0]      awaddr;
    logic                   w_got;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } sbo_main_s;

  sbo_main_s           st_r;
  sbo_main_s           st_nxt;
  logic [N_SHARED-1:0] link_shreg;
  logic                link_ser_out;
  logic                ld_fell;
  logic                pg_rose;
  logic [N_SHARED-1:0] pin_en_n;
  logic                running;

  // Maps a three-level strap code to 0, 1 or 2.
  function automatic logic [3:0] tri_value(input logic [1:0] code);
    logic [3:0] v;
    v = 4'h1;
    if (code == TRI_LOW) begin
      v = 4'h0;
    end else if (code == TRI_HIGH) begin
      v = 4'h2;
    end
    return v;
  endfunction

  // Nine addresses from two straps: the high strap selects a group of three.
  // Code three reads as the middle level, so every strap setting yields an address.
  function automatic logic [BADDR_W-1:0] decode_addr(input logic [1:0] hi,
                                                     input logic [1:0] lo);
    logic [7:0] idx;
    idx = {4'h0, tri_value(hi)} * {4'h0, TRI_LEVELS} + {4'h0, tri_value(lo)};
    return ADDR_BASE + idx[BADDR_W-1:0];
  endfunction

  // Link-domain shift register clocked by the serial clock pin.
  sbo_link_shift u_link (
    .link_clk_i     (OUT5_ENABLE_OR_SERIAL_CLOCK_I),
    .rst_n_i        (RSTN_I),
    .sb_mode_i      (st_r.sb_mode),
    .shift_load_n_i (OUT13_ENABLE_OR_SHIFT_LOAD_N_I),
    .serial_in_i    (OUT9_ENABLE_OR_SERIAL_IN_I),
    .shreg_o        (link_shreg),
    .serial_out_o   (link_ser_out)
  );

  // Edges seen on the synchronised pins; only second and later stages are compared.
  assign ld_fell = st_r.ld_sync[2] && !st_r.ld_sync[1];
  assign pg_rose = st_r.pg_sync[1] && !st_r.pg_sync[2];
  assign running = (st_r.state == ST_RUN);

  // Per-output active-low enable from the pins or from the side-band control word.
  always_comb begin
    if (st_r.sb_mode) begin
      // Side-band mode: the loaded control word stands in for the shared pins.
      pin_en_n = st_r.sb_ctl;
    end else begin
      // Enable mode: each shared pin is the active-low enable of its own output.
      pin_en_n           = '1;
      pin_en_n[SH_OUT2]  = st_r.out2_sync[1];
      pin_en_n[SH_OUT5]  = st_r.diff_output_5_sync[1];
      pin_en_n[SH_OUT9]  = st_r.in9_sync[1];
      pin_en_n[SH_OUT13] = st_r.ld_sync[1];
    end
  end

  // Next state of the whole block.
  always_comb begin
    st_nxt = st_r;

    // Every pin passes two flops before use.
    // The pin copies feed the enable mux too, so none is read before its second flop.
    st_nxt.strap_sync  = {st_r.strap_sync[0], SIDEBAND_SELECT_STRAP_I};
    st_nxt.pg_sync     = {st_r.pg_sync[1:0], POWER_GOOD_POWERDOWN_N_I};
    st_nxt.ld_sync     = {st_r.ld_sync[1:0], OUT13_ENABLE_OR_SHIFT_LOAD_N_I};
    st_nxt.in9_sync    = {st_r.in9_sync[0], OUT9_ENABLE_OR_SERIAL_IN_I};
    st_nxt.diff_output_5_sync   = {st_r.diff_output_5_sync[0], OUT5_ENABLE_OR_SERIAL_CLOCK_I};
    st_nxt.out2_sync   = {st_r.out2_sync[0], OUT2_ENABLE_OR_SERIAL_OUT_I};
    st_nxt.ded_sync    = {st_r.ded_sync[0], DED_ENABLE_N_I};
    st_nxt.adr_hi_sync = {st_r.adr_hi_sync[0], BUS_ADDRESS_STRAP_HI_I};
    st_nxt.adr_lo_sync = {st_r.adr_lo_sync[0], BUS_ADDRESS_STRAP_LO_I};

    // Straps are caught once; the mode then holds until reset, whatever the board does with the strap.
    unique case (st_r.state)
      ST_WAIT_PG: begin
        if (pg_rose) begin
          st_nxt.sb_mode  = st_r.strap_sync[1];
          st_nxt.bus_addr = decode_addr(st_r.adr_hi_sync[1], st_r.adr_lo_sync[1]);
          st_nxt.state    = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!st_r.pg_sync[1]) begin
          st_nxt.state = ST_PWRDN;
        end
      end
      ST_PWRDN: begin
        if (st_r.pg_sync[1]) begin
          st_nxt.state = ST_RUN;
        end
      end
      default: begin
        // An illegal code parks the block powered down; no strap is sampled again.
        st_nxt.state = ST_PWRDN;
      end
    endcase

    // Shifting is off while the load pin is low, so the link word is stable when sampled.
    if (st_r.sb_mode && ld_fell) begin
      st_nxt.sb_ctl = link_shreg;
    end

    // An output drives only while running and every enable that applies agrees.
    st_nxt.out_en  = running ? (st_r.ctrl[N_SHARED-1:0] & ~pin_en_n) : '0;
    st_nxt.ded_en  = running ? (st_r.ctrl[CTRL_W-1:CTRL_DED_LSB] & ~st_r.ded_sync[1])
                             : '0;
    // Status and pin bias follow the registered state one cycle late.
    st_nxt.pwrdn   = (st_r.state == ST_PWRDN);
    st_nxt.pull_up = !st_r.sb_mode;
    st_nxt.out2_oe = st_r.sb_mode;

    // Write channel: address and data are taken in either order.
    if (AXI_REQ_I.awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = AXI_REQ_I.awaddr;
    end
    if (AXI_REQ_I.wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = AXI_REQ_I.wdata;
      st_nxt.wstrb = AXI_REQ_I.wstrb;
    end
    // The response leaves once the master has taken it.
    if (st_r.bvalid && AXI_REQ_I.bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // Both halves in hand: commit the write and raise the response.
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      unique case (st_r.awaddr)
        OFS_OE_CTRL: begin
          // Only the low byte holds enable bits, so only its strobe matters.
          if (st_r.wstrb[0]) begin
            st_nxt.ctrl = st_r.wdata[CTRL_W-1:0];
          end
        end
        OFS_STATUS, OFS_SB_CTL, OFS_BUS_ADDR: begin
          st_nxt.bresp = RESP_OKAY; // Read-only words ignore writes.
        end
        default: begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read channel: data is answered one cycle after the address is taken.
    // Read data leaves once the master has taken it.
    if (st_r.rvalid && AXI_REQ_I.rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // A taken address is decoded at once; unmapped words answer with an error.
    if (AXI_REQ_I.arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = '0;
      st_nxt.rresp  = RESP_OKAY;
      unique case (AXI_REQ_I.araddr)
        OFS_OE_CTRL: begin
          st_nxt.rdata[CTRL_W-1:0] = st_r.ctrl;
        end
        OFS_STATUS: begin
          st_nxt.rdata[STAT_SB_MODE] = st_r.sb_mode;
          st_nxt.rdata[STAT_RUN]     = running;
          st_nxt.rdata[STAT_PWRDN]   = st_r.pwrdn;
        end
        OFS_SB_CTL: begin
          st_nxt.rdata[N_SHARED-1:0] = st_r.sb_ctl;
        end
        OFS_BUS_ADDR: begin
          st_nxt.rdata[BADDR_W-1:0] = st_r.bus_addr;
        end
        default: begin
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Ready stays low while a transfer is held, which gives one write and one read at a time.
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;

    // Synchronous reset; the synchronisers are cleared too so no stale edge is seen.
    if (!RSTN_I) begin
      // Everything not named here clears to zero, the ready flags included.
      st_nxt          = '0;
      st_nxt.pg_sync  = '0;
      st_nxt.ld_sync  = '0;
      st_nxt.state    = ST_WAIT_PG;
      st_nxt.bus_addr = BADDR_RST;
      st_nxt.ctrl     = OE_CTRL_RST;
      st_nxt.sb_ctl   = SB_CTL_RST;
      st_nxt.pull_up  = 1'b1;
      st_nxt.bresp    = RESP_OKAY;
      st_nxt.rresp    = RESP_OKAY;
    end
  end

  // One register for the whole reference-domain state.
  always_ff @(posedge REF_CLK_I) begin
    st_r <= st_nxt;
  end

  // Outputs come straight from flops.
  assign AXI_RSP_O.awready = st_r.awready;
  assign AXI_RSP_O.wready  = st_r.wready;
  assign AXI_RSP_O.bresp   = st_r.bresp;
  assign AXI_RSP_O.bvalid  = st_r.bvalid;
  assign AXI_RSP_O.arready = st_r.arready;
  assign AXI_RSP_O.rdata   = st_r.rdata;
  assign AXI_RSP_O.rresp   = st_r.rresp;
  assign AXI_RSP_O.rvalid  = st_r.rvalid;

  // Pin-side outputs; the serial data flop lives in the link domain.
  assign OUT2_ENABLE_OR_SERIAL_OUT_O    = link_ser_out;
  assign OUT2_ENABLE_OR_SERIAL_OUT_OE_O = st_r.out2_oe;
  assign SHARED_PIN_PULL_UP_O           = st_r.pull_up;
  assign DIFF_OUTPUT_EN_O               = st_r.out_en;
  assign DED_OUTPUT_EN_O                = st_r.ded_en;
  assign POWER_DOWN_O                   = st_r.pwrdn;
  assign BUS_ADDRESS_O                  = st_r.bus_addr;

endmodule
`default_nettype wire
